/* File: src/eis_irq.sv */
// Interrupt signalling: sources, pulse sequencer, repeat timer
// ----------------------------------------------------------------
// Summary of operation
// - Active modes: pin low for pulse time
// - Pin stays high at least separation time; code skips the gap after a pulse cut short by mode loss
// - Interrupts never change device mode
// - One mask enables each status group
// - Groups are ORs of status registers
// - Supply faults, stage2 shutdown, POR excluded
// - Wake event counts only if enabled, except at stop entry
// - Wake: CAN, pin, timers, brake faults
// - Masked and wake methods work together
// - Pending SPI/CRC failures repeat periodically; code starts the repeat period only at a pulse start while one is pending
// - No pulses in restart, fail-safe, sleep
// - Stop entry with pending wake fires
// - Status snapshot taken at falling edge
// - Events stay pending until host clears
// - In init pin selects development mode
// - Software can disable repeat pulses
// - Events during low merge into one
// - Push-pull output, driven high and low
// - Init to normal with pin active fires
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module eis_irq
    import eis_pkg::*;
#(
    parameter int PULSE_CYC = EIS_PULSE_CYC,
    parameter int SEP_CYC = EIS_SEP_CYC,
    parameter int REPEAT_CYC = EIS_REPEAT_CYC,
    parameter int STAT_W = EIS_STAT_W,
    parameter int WAKE_W = EIS_WAKE_W,
    parameter int BRK_W = EIS_BRK_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire eis_pkg::eis_mode_t dev_mode,
    input wire eis_pkg::eis_src_t irq_mask,
    input wire logic [STAT_W-1:0] supply_status,
    input wire logic [STAT_W-1:0] thermal_status_reg,
    input wire logic [STAT_W-1:0] bus_status,
    input wire logic [STAT_W-1:0] highside_fault_reg,
    input wire logic [STAT_W-1:0] drain_source_fault_reg,
    input wire logic [STAT_W-1:0] device_status_reg,
    input wire logic [WAKE_W-1:0] wake_status_reg,
    input wire logic [WAKE_W-1:0] wake_src_enable,
    input wire logic [BRK_W-1:0] lowside_brake_fault,
    input wire logic brake_feature_enable,
    input wire logic wake_static_sense,
    input wire logic wake_pin_level,
    input wire logic repeat_irq_enable,
    input wire logic irq_pin_in,
    output logic irq_out_low_active,
    output logic irq_oe,
    output eis_pkg::eis_src_t status_field,
    output logic [WAKE_W-1:0] wake_field,
    output logic sw_dev_mode_select,
    output logic wake_pin_set
);
    import eis_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    eis_src_t src;                    // Unmasked group flags
    eis_src_t masked;                 // Groups after the mask
    logic wake_act;                   // Any enabled wake event
    logic [6:0] events;               // Group and wake causes
    logic [6:0] event_rise;           // Newly raised causes
    eis_mode_t mode_prev_r;           // Mode one cycle earlier
    logic mode_act;                   // Normal or stop
    logic stop_entry;                 // Entry into stop with wake pending
    logic init_to_normal;             // Static wake pin seen at init exit
    logic rep_cond;                   // Repeat pulses wanted
    logic rep_last;                   // Repeat period expiring
    logic rep_load;                   // Restart repeat period
    logic rep_fire;                   // Repeat request
    logic req_any;                    // Any request this cycle
    logic req_pend_r;                 // Request waiting for a pulse
    eis_state_t state_r;              // Sequencer state
    eis_state_t state_nxt;            // Sequencer next state
    logic tmr_load;                   // Load pulse or gap timer
    logic [EIS_TMR_W-1:0] tmr_val;    // Value for that timer
    logic tmr_last;                   // Timer in final cycle
    logic irq_out_low_active_r;       // Pin level register
    logic irq_oe_r;                   // Pin drive enable register
    eis_src_t status_field_r;         // Group snapshot
    logic [WAKE_W-1:0] wake_field_r;  // Wake snapshot
    logic sw_dev_mode_select_r;       // Development mode request
    logic wake_pin_set_r;             // Wake pin status set pulse

    // ----------------------------------------------------------------
    // Source groups
    // ----------------------------------------------------------------
    // Each group is the OR of its status register, spi_crc of the SPI
    // and CRC failure bits only, the mode-forcing faults left out
    always_comb begin
        logic [STAT_W-1:0] sup_keep;
        logic [STAT_W-1:0] th_keep;
        sup_keep = supply_status;
        sup_keep[EIS_SUP_POR_BIT] = 1'b0;
        sup_keep[EIS_SUP_UV_BIT] = 1'b0;
        sup_keep[EIS_SUP_SC_BIT] = 1'b0;
        sup_keep[EIS_SUP_OV_BIT] = 1'b0;
        th_keep = thermal_status_reg;
        th_keep[EIS_THERMAL_SHUTDOWN_STAGE2_BIT] = 1'b0;
        src.supply = |sup_keep;
        src.thermal = |th_keep;
        src.bus = |bus_status;
        src.highside_group_flag = |highside_fault_reg;
        src.bridge_group_flag = |drain_source_fault_reg;
        src.spi_crc = device_status_reg[EIS_SPI_FAIL_BIT] | device_status_reg[EIS_CRC_FAIL_BIT];
    end

    // One mask bit per group
    assign masked = src & irq_mask;

    // Wake events count only for inputs enabled as wake sources;
    // brake faults count while a brake feature is enabled
    assign wake_act = (|(wake_status_reg & wake_src_enable))
        | (brake_feature_enable & (|lowside_brake_fault));

    // Both methods feed the same request path
    assign events = {masked, wake_act};

    // New causes only; a cause held set raises one request
    eis_rise #(
        .W(7)
    ) u_rise (
        .clk(clk),
        .rst_n(rst_n),
        .level(events),
        .rise(event_rise)
    );

    // ----------------------------------------------------------------
    // Mode tracking
    // ----------------------------------------------------------------
    // Mode is only read here, this block never drives it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_prev_r <= EIS_MODE_INIT;
        end else begin
            mode_prev_r <= dev_mode;
        end
    end

    // Pulses only in normal and stop
    assign mode_act = (dev_mode == EIS_MODE_NORMAL) || (dev_mode == EIS_MODE_STOP);

    // Stop entry with wake or brake bits still set
    assign stop_entry = (dev_mode == EIS_MODE_STOP) && (mode_prev_r != EIS_MODE_STOP)
        && ((|wake_status_reg) || (|lowside_brake_fault));

    // Leaving init for normal with static sense and pin active
    assign init_to_normal = (mode_prev_r == EIS_MODE_INIT) && (dev_mode == EIS_MODE_NORMAL)
        && wake_static_sense && wake_pin_level;

    // ----------------------------------------------------------------
    // Repeat timer
    // ----------------------------------------------------------------
    // Only a pending SPI or CRC failure repeats, and only if enabled
    assign rep_cond = repeat_irq_enable && masked.spi_crc && mode_act;

    // Period restarts at each pulse start and is cleared to zero whenever it is not wanted
    assign rep_load = !rep_cond || ((state_nxt == EIS_ST_LOW) && (state_r != EIS_ST_LOW));

    eis_timer #(
        .W(EIS_REP_W)
    ) u_rep_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .load(rep_load),
        .load_val(rep_cond ? EIS_REP_W'(REPEAT_CYC) : '0),
        .last(rep_last)
    );

    assign rep_fire = rep_cond && rep_last;

    // ----------------------------------------------------------------
    // Request latch
    // ----------------------------------------------------------------
    assign req_any = (|event_rise) || stop_entry || init_to_normal || rep_fire;

    // Held until a pulse starts; requests during the low phase
    // fold into that pulse; dropped outside the active modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_pend_r <= 1'b0;
        end else if (!mode_act) begin
            req_pend_r <= 1'b0;
        end else if ((state_nxt == EIS_ST_LOW) || (state_r == EIS_ST_LOW)) begin
            // Whole low phase, final cycle too, absorbs requests
            req_pend_r <= 1'b0;
        end else if (req_any) begin
            req_pend_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pulse sequencer
    // ----------------------------------------------------------------
    // Idle, low for the pulse time, high for the gap time
    always_comb begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_val = '0;
        case (state_r)
            EIS_ST_IDLE: begin
                // Start a pulse on a pending or fresh request
                if (mode_act && (req_pend_r || req_any)) begin
                    state_nxt = EIS_ST_LOW;
                    tmr_load = 1'b1;
                    tmr_val = EIS_TMR_W'(PULSE_CYC);
                end
            end
            EIS_ST_LOW: begin
                // Release at pulse end, or at once on mode loss
                if (!mode_act) begin
                    state_nxt = EIS_ST_IDLE;
                end else if (tmr_last) begin
                    state_nxt = EIS_ST_GAP;
                    tmr_load = 1'b1;
                    tmr_val = EIS_TMR_W'(SEP_CYC);
                end
            end
            EIS_ST_GAP: begin
                // Hold high for the whole separation
                if (tmr_last) begin
                    state_nxt = EIS_ST_IDLE;
                end
            end
            default: begin
                state_nxt = EIS_ST_IDLE;
            end
        endcase
    end

    eis_timer #(
        .W(EIS_TMR_W)
    ) u_seq_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .last(tmr_last)
    );

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= EIS_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Push-pull: driven high and low outside init
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_low_active_r <= 1'b1;
            irq_oe_r <= 1'b0;
        end else begin
            irq_out_low_active_r <= (state_nxt != EIS_ST_LOW);
            irq_oe_r <= (dev_mode != EIS_MODE_INIT);
        end
    end

    // In init the pin is an input; low asks for development mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_dev_mode_select_r <= 1'b0;
        end else if (dev_mode == EIS_MODE_INIT) begin
            sw_dev_mode_select_r <= !irq_pin_in;
        end
    end

    // ----------------------------------------------------------------
    // Status snapshot and wake pin set
    // ----------------------------------------------------------------
    // Readable copy refreshed on each falling edge of the pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_field_r <= '0;
            wake_field_r <= '0;
        end else if ((state_nxt == EIS_ST_LOW) && (state_r != EIS_ST_LOW)) begin
            status_field_r <= src;
            wake_field_r <= wake_status_reg & wake_src_enable;
        end
    end

    // One-cycle request to the wake unit to set the pin status bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_pin_set_r <= 1'b0;
        end else begin
            wake_pin_set_r <= init_to_normal;
        end
    end

    assign irq_out_low_active = irq_out_low_active_r;
    assign irq_oe = irq_oe_r;
    assign status_field = status_field_r;
    assign wake_field = wake_field_r;
    assign sw_dev_mode_select = sw_dev_mode_select_r;
    assign wake_pin_set = wake_pin_set_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [15:0] low_len_r;  // Length of the current low phase
    logic [15:0] high_len_r; // Length of the current high phase

    // Phase length counters read by the checks only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_len_r <= '0;
            high_len_r <= 16'hffff;
        end else if (!irq_out_low_active_r) begin
            low_len_r <= low_len_r + 16'h1;
            high_len_r <= '0;
        end else begin
            low_len_r <= '0;
            high_len_r <= (high_len_r == 16'hffff) ? high_len_r : high_len_r + 16'h1;
        end
    end

    AST_PULSE_LEN: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(irq_out_low_active_r) && mode_act) |-> (low_len_r == 16'(PULSE_CYC)))
        else $error("Low pulse length differs from pulse time");

    AST_MIN_GAP: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(irq_out_low_active_r) |-> ($past(high_len_r) >= 16'(SEP_CYC)))
        else $error("High time between pulses too short");

    AST_QUIET_MODES: assert property (@(posedge clk) disable iff (!rst_n)
        (!mode_act && !$past(mode_act)) |-> ##1 irq_out_low_active_r)
        else $error("Pulse driven outside normal and stop");

    AST_INIT_INPUT: assert property (@(posedge clk) disable iff (!rst_n)
        (dev_mode == EIS_MODE_INIT) |=> !irq_oe_r)
        else $error("Pin driven during init");

    AST_PUSH_PULL: assert property (@(posedge clk) disable iff (!rst_n)
        (dev_mode != EIS_MODE_INIT) |=> irq_oe_r)
        else $error("Pin not driven outside init");

    AST_SNAPSHOT: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(irq_out_low_active_r) |-> (status_field_r == $past(src)))
        else $error("Snapshot not taken at falling edge");

    AST_MERGE: assert property (@(posedge clk) disable iff (!rst_n)
        (!irq_out_low_active_r && req_any && mode_act) |=> !req_pend_r)
        else $error("Event during low left a second request");

    AST_STOP_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
        (stop_entry && state_r == EIS_ST_IDLE) |=> !irq_out_low_active_r)
        else $error("Stop entry with pending wake gave no pulse");

    AST_WAKE_SET: assert property (@(posedge clk) disable iff (!rst_n)
        init_to_normal |=> (wake_pin_set_r && !irq_out_low_active_r))
        else $error("Init exit with active pin not signalled");

    AST_NO_REPEAT: assert property (@(posedge clk) disable iff (!rst_n)
        !repeat_irq_enable |-> !rep_fire)
        else $error("Repeat pulse while repeats disabled");

    AST_EXCLUDED: assert property (@(posedge clk) disable iff (!rst_n)
        (supply_status[EIS_SUP_UV_BIT] && !(|(supply_status & 8'hf0)) && !(|supply_status[7:4]))
        |-> !src.supply)
        else $error("Excluded supply bit raised a source");
endmodule
`default_nettype wire

/* File: src/eis_pkg.sv */
// Shared constants and types of the interrupt signalling block
package eis_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int EIS_CLK_MHZ = 20;          // Oscillator rate in MHz
    localparam int EIS_PULSE_US = 100;        // Low time of one pulse, us
    localparam int EIS_SEP_US = 100;          // Least high time between pulses, us
    localparam int EIS_REPEAT_US = 10000;     // Period of repeat pulses, us
    localparam int EIS_PULSE_CYC = EIS_PULSE_US * EIS_CLK_MHZ;
    localparam int EIS_SEP_CYC = EIS_SEP_US * EIS_CLK_MHZ;
    localparam int EIS_REPEAT_CYC = EIS_REPEAT_US * EIS_CLK_MHZ;
    localparam int EIS_TMR_W = 16;            // Pulse and gap timer width
    localparam int EIS_REP_W = 24;            // Repeat timer width

    // ----------------------------------------------------------------
    // Status vector layout
    // ----------------------------------------------------------------
    localparam int EIS_STAT_W = 8;            // Width of each status group
    localparam int EIS_WAKE_W = 4;            // Wake status width
    localparam int EIS_BRK_W = 3;             // Low-side brake bits
    localparam int EIS_SUP_POR_BIT = 0;       // Power-on reset flag
    localparam int EIS_SUP_UV_BIT = 1;        // Main supply undervoltage
    localparam int EIS_SUP_SC_BIT = 2;        // Main supply short
    localparam int EIS_SUP_OV_BIT = 3;        // Main supply overvoltage
    localparam int EIS_THERMAL_SHUTDOWN_STAGE2_BIT = 0;          // Second thermal shutdown
    localparam int EIS_SPI_FAIL_BIT = 0;      // SPI failure in device status
    localparam int EIS_CRC_FAIL_BIT = 1;      // CRC failure in device status
    localparam int EIS_WK_CAN_BIT = 0;        // CAN pattern or frame
    localparam int EIS_WK_PIN_BIT = 1;        // Wake pin
    localparam int EIS_WK_TMR1_BIT = 2;       // Cyclic wake timer 1
    localparam int EIS_WK_TMR2_BIT = 3;       // Cyclic wake timer 2

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Device operating modes
    typedef enum logic [2:0] {
        EIS_MODE_INIT = 3'h0,
        EIS_MODE_NORMAL = 3'h1,
        EIS_MODE_STOP = 3'h3,
        EIS_MODE_SLEEP = 3'h2,
        EIS_MODE_RESTART = 3'h6,
        EIS_MODE_FAILSAFE = 3'h7
    } eis_mode_t;

    // Pulse sequencer states, Gray along idle, low, gap
    typedef enum logic [1:0] {
        EIS_ST_IDLE = 2'h0,
        EIS_ST_LOW = 2'h1,
        EIS_ST_GAP = 2'h3
    } eis_state_t;

    // Interrupt source groups, one mask bit each
    typedef struct packed {
        logic supply;
        logic thermal;
        logic bus;
        logic highside_group_flag;
        logic bridge_group_flag;
        logic spi_crc;
    } eis_src_t;

    // Reset value of the mask: all groups enabled
    localparam eis_src_t EIS_MASK_RST = 6'h3f;

endpackage

/* File: src/eis_timer.sv */
// Loadable down counter with a last-cycle flag
`timescale 1ns/1ps
`default_nettype none
module eis_timer #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic last
);
    import eis_pkg::*;

    logic [W-1:0] count_r; // Remaining cycles

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Load wins; otherwise count down to zero and stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= load_val;
        end else if (count_r != '0) begin
            count_r <= count_r - W'(1);
        end
    end

    // High in the final counted cycle
    assign last = (count_r == W'(1));
endmodule
`default_nettype wire

/* File: src/eis_rise.sv */
// Per-bit rising edge detector for a level vector
`timescale 1ns/1ps
`default_nettype none
module eis_rise #(
    parameter int W = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise
);
    import eis_pkg::*;

    logic [W-1:0] prev_r; // Level one cycle earlier

    // ----------------------------------------------------------------
    // Edge detect
    // ----------------------------------------------------------------
    // Reset to zero so a source already set counts as new
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '0;
        end else begin
            prev_r <= level;
        end
    end

    assign rise = level & ~prev_r;
endmodule
`default_nettype wire

/* File: tb/eis_host_model.sv */
// Host side of the interrupt pin: strap driver and pulse monitor
`timescale 1ns/1ps
`default_nettype none
module eis_host_model (
    input wire logic clk,
    input wire logic pin_val,
    input wire logic pin_oe,
    input wire logic strap_en,
    output logic pin_in,
    output int pulse_cnt,
    output int low_len,
    output int min_high
);
    logic lvl_r = 1'b1; // Last level the device drove
    logic drift_r = 1'b0; // Undriven wire changes every cycle
    int run_r = 0; // Cycles spent at the current level
    // ----------------------------------------------------------------
    // Wire resolution
    // ----------------------------------------------------------------
    always_comb begin
        if (pin_oe) pin_in = pin_val;
        else if (strap_en) pin_in = 1'b0;
        else pin_in = drift_r;
    end
    initial begin
        pulse_cnt = 0;
        low_len = 0;
        min_high = 1000000;
    end
    // ----------------------------------------------------------------
    // Pulse monitor: counts falls, measures low and high times
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        drift_r <= ~drift_r;
        if (pin_oe && pin_val !== lvl_r) begin
            lvl_r <= pin_val;
            run_r <= 1;
            if (!pin_val) begin
                pulse_cnt <= pulse_cnt + 1;
                if (pulse_cnt > 0 && run_r < min_high) min_high <= run_r;
            end else low_len <= run_r;
        end else run_r <= run_r + 1;
    end
endmodule
`default_nettype wire

/* File: tb/test_eis_irq.sv */
// Self-checking bench of the interrupt signalling block
`timescale 1ns/1ps
`default_nettype none
module test_eis_irq;
    import eis_pkg::*;
    localparam int PULSE = 4; // Short low time for simulation
    localparam int SEP = 3; // Short gap for simulation
    logic clk, rst_n, brk_en, ss, pin_lvl, rep_en, pin_in, oe, pin, sel, wps, wps_seen;
    eis_mode_t dev_mode;
    eis_src_t irq_mask, status_field;
    logic [7:0] sup, thr, bus, hs, ds, dst;
    logic [3:0] wk, wk_en, wake_field;
    logic [2:0] brk;
    int pulse_cnt, low_len, min_high, base, fails, cmp_count;
    eis_mode_t off_modes[3] = '{EIS_MODE_SLEEP, EIS_MODE_RESTART, EIS_MODE_FAILSAFE};
    eis_irq #(.PULSE_CYC(PULSE), .SEP_CYC(SEP), .REPEAT_CYC(40)) DUT (.clk(clk), .rst_n(rst_n),
        .dev_mode(dev_mode), .irq_mask(irq_mask), .supply_status(sup), .thermal_status_reg(thr),
        .bus_status(bus), .highside_fault_reg(hs), .drain_source_fault_reg(ds), .device_status_reg(dst),
        .wake_status_reg(wk), .wake_src_enable(wk_en), .lowside_brake_fault(brk),
        .brake_feature_enable(brk_en), .wake_static_sense(ss), .wake_pin_level(pin_lvl),
        .repeat_irq_enable(rep_en), .irq_pin_in(pin_in), .irq_out_low_active(pin), .irq_oe(oe),
        .status_field(status_field), .wake_field(wake_field), .sw_dev_mode_select(sel), .wake_pin_set(wps));
    eis_host_model host (.clk(clk), .pin_val(pin), .pin_oe(oe), .strap_en(dev_mode == EIS_MODE_INIT),
        .pin_in(pin_in), .pulse_cnt(pulse_cnt), .low_len(low_len), .min_high(min_high));
    // ----------------------------------------------------------------
    // Clock and helpers
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Catch the one-cycle wake pin flag
    always @(posedge clk) if (wps === 1'b1) wps_seen <= 1'b1;
    task automatic run(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Wait, then compare pulses since the last call
    task automatic pulses(input int n, input int w);
        run(w);
        chk("pulse count", n, pulse_cnt - base);
        base = pulse_cnt;
    endtask
    task automatic set_grp(input int g, input logic [7:0] v);
        case (g)
            5: sup = v;
            4: thr = v;
            3: bus = v;
            2: hs = v;
            1: ds = v;
            default: dst = v;
        endcase
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        run(5000);
        fails++;
        tally_and_finish;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, brk_en, rep_en, sup, thr, bus, hs, ds, dst, wk, wk_en, brk, wps_seen} = '0;
        {ss, pin_lvl} = 2'b11;
        fails = 0;
        cmp_count = 0;
        base = 0;
        dev_mode = EIS_MODE_INIT;
        irq_mask = EIS_MASK_RST;
        run(12);
        rst_n = 1'b1;
        run(2);
        chk("dev select", 1, 32'(sel));
        chk("pin drive", 0, 32'(oe));
        dev_mode = EIS_MODE_NORMAL;
        pulses(1, 20);
        chk("wake pin set", 1, 32'(wps_seen));
        chk("push-pull", 1, 32'(oe));
        // Each group alone, with its snapshot
        for (int g = 0; g < 6; g++) begin
            set_grp(g, (g == 5) ? 8'h10 : (g == 4) ? 8'h02 : 8'h01);
            pulses(1, 20);
            chk("low time", PULSE, low_len);
            chk("status field", 32'h1 << g, 32'(status_field));
            set_grp(g, 8'h00);
            chk("status reread", 32'h1 << g, 32'(status_field));
        end
        sup = 8'h0f;
        thr = 8'h01;
        pulses(0, 20);
        {sup, thr} = '0;
        irq_mask = 6'h37;
        bus = 8'h80;
        pulses(0, 20);
        bus = 8'h00;
        run(2);
        irq_mask = EIS_MASK_RST;
        wk = 4'h1;
        pulses(0, 20);
        dev_mode = EIS_MODE_STOP;
        pulses(1, 20);
        wk = 4'h0;
        dev_mode = EIS_MODE_NORMAL;
        wk_en = 4'hf;
        for (int i = 0; i < 4; i++) begin
            wk = 4'h1 << i;
            pulses(1, 20);
            chk("wake field", 32'h1 << i, 32'(wake_field));
            wk = 4'h0;
            run(2);
        end
        brk_en = 1'b1;
        brk = 3'h4;
        bus = 8'h01;
        pulses(1, 20);
        {brk, bus} = '0;
        run(2);
        // Second event while low, third in the gap
        bus = 8'h01;
        run(2);
        hs = 8'h01;
        run(4);
        ds = 8'h01;
        pulses(2, 30);
        chk("gap ok", 1, 32'(min_high >= SEP));
        {bus, hs, ds} = '0;
        rep_en = 1'b1;
        dst = 8'h02;
        pulses(3, 100);
        dst = 8'h00;
        bus = 8'h01;
        pulses(1, 100);
        bus = 8'h00;
        rep_en = 1'b0;
        dst = 8'h01;
        pulses(1, 100);
        dst = 8'h00;
        foreach (off_modes[k]) begin
            dev_mode = off_modes[k];
            bus = 8'h01;
            pulses(0, 20);
            bus = 8'h00;
            run(2);
        end
        dev_mode = EIS_MODE_NORMAL;
        pulses(0, 20);
        tally_and_finish;
    end
endmodule
`default_nettype wire
